//--- verilog/fcpi_consts.svh
// Constants of the flash controller with block protection and interrupts.
//
// Contract
// RQ1: An erase clears exactly one 1 kB erase block chosen by its start address to all ones.
// RQ2: Protection is held per 2 kB block of two erase blocks, each read/write, read-only or fetch-only.
// RQ3: A read-only block refuses erase and program but still serves data reads and fetches.
// RQ4: A fetch-only block refuses erase and program and serves only instruction fetches.
// RQ5: Programming writes one word and stores the old word ANDed with the new, any number of times.
// RQ6: Program and erase pulses are timed by counting clocks against a software cycles-per-microsecond value.
// RQ7: Any disallowed access sets the access-violation interrupt source.
// RQ8: A finished program or erase sets the separate completion interrupt source.
// RQ9: Protection acts at once without being saved, and saving it is a separate irreversible step.
// RQ10: Each of the two sources has its own enable, and only enabled sources drive the interrupt line.
// RQ11: Raw status and masked status are readable as separate fields for both sources.
// RQ12: Software clears each source on its own, and it stays clear until a new event.
// RQ13: The interrupt handler should clear its source early since the clear write may land late.
// RQ14: The requester gives program addresses and counts that are whole multiples of four.
// RQ15: Protection may only be tightened, a fetch-only block is frozen, and loosening is refused.
// RQ16: A source is cleared by writing one to its bit of the clear register, and zero leaves it alone.
// RQ17: An erase or program aimed at a protected block or outside the flash leaves the array and flags a violation.
`ifndef FCPI_CONSTS_SVH
`define FCPI_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FCPI_OFF_ADDR 8'h00
`define FCPI_OFF_DATA 8'h04
`define FCPI_OFF_CMD 8'h08
`define FCPI_OFF_USEC 8'h0c
`define FCPI_OFF_RAW 8'h10
`define FCPI_OFF_EN 8'h14
`define FCPI_OFF_MSK 8'h18
`define FCPI_OFF_CLR 8'h1c
`define FCPI_OFF_PROT 8'h20
`define FCPI_OFF_STAT 8'h24
`define FCPI_OFF_SAVED 8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FCPI_INT_ACC 0
`define FCPI_INT_DONE 1
`define FCPI_CMD_PROG 0
`define FCPI_CMD_ERASE 1
`define FCPI_CMD_SAVE 2
`define FCPI_STAT_BUSY 0
`define FCPI_STAT_SAVED 1

// ----------------------------------------------------------------
// Protection encodings and geometry
// ----------------------------------------------------------------
`define FCPI_PROT_RW 2'h0
`define FCPI_PROT_RO 2'h1
`define FCPI_PROT_XO 2'h2
`define FCPI_NUM_PB 4
`define FCPI_WORDS 2048
`define FCPI_AW 11
`define FCPI_EB_AW 8
`define FCPI_EB_LAST 8'hff
`define FCPI_BYTE_AW 13
`define FCPI_EB_OFS_BITS 10
`define FCPI_PB_LSB 11
`define FCPI_ERASED 32'hffffffff

// ----------------------------------------------------------------
// Read kinds and timing
// ----------------------------------------------------------------
`define FCPI_RD_FETCH 2'h0
`define FCPI_RD_DATA 2'h1
`define FCPI_RD_DEBUG 2'h2
`define FCPI_CLK_MHZ 16'h0064
`define FCPI_PROG_US 16'h0014
`define FCPI_ERASE_US 16'h2ee0

`endif

//--- verilog/fcpi_pkg.sv
// Types shared by the flash controller files.
`default_nettype none
`include "fcpi_consts.svh"
package fcpi_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_APPLY} fcpi_state_t;
  typedef logic [1:0] fcpi_prot_t;
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [31:0] addr;
  } fcpi_rd_req_t;
  typedef struct packed {
    logic valid;
    logic denied;
    logic [31:0] data;
  } fcpi_rd_rsp_t;
endpackage
`default_nettype wire

//--- verilog/fcpi_array.sv
// Word-wide flash storage array with AND-programming and erase writes.
`timescale 1ns/1ps
`default_nettype none
`include "fcpi_consts.svh"
module fcpi_array (
  // Clock.
  input wire logic i_clk,
  // Write port.
  input wire logic i_we,
  input wire logic i_erase,
  input wire logic [`FCPI_AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  // Read port.
  input wire logic [`FCPI_AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Contents hold no reset, like real flash cells; erase before trusting them.
  logic [31:0] mem [0:`FCPI_WORDS-1];

  // Program can only pull bits low, so only an erase returns a zero to one.
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      if (i_erase)
        mem[i_waddr] <= `FCPI_ERASED; // RQ1
      else
        mem[i_waddr] <= mem[i_waddr] & i_wdata; // RQ5
    end
  end

  // Read is combinational; the controller registers it.
  assign o_rdata = mem[i_raddr];

endmodule
`default_nettype wire

//--- verilog/fcpi_top.sv
// Flash controller top: AHB-Lite registers, protection, pulse timing and interrupts.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fcpi_consts.svh"
module fcpi_top #(
  parameter logic [15:0] PROG_US = `FCPI_PROG_US,
  parameter logic [15:0] ERASE_US = `FCPI_ERASE_US
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Fetch, data and debug read port.
  input wire fcpi_pkg::fcpi_rd_req_t i_rd,
  output fcpi_pkg::fcpi_rd_rsp_t o_rd,
  // Interrupt and status.
  output logic o_irq,
  output logic o_busy
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // True when a byte address falls inside the array.
  function automatic logic in_range(input logic [31:0] a);
    in_range = (a[31:`FCPI_BYTE_AW] == '0);
  endfunction

  // Protection block index of a byte address.
  function automatic logic [1:0] pb_of(input logic [31:0] a);
    pb_of = a[`FCPI_PB_LSB+1:`FCPI_PB_LSB];
  endfunction

  // A change is allowed only when it keeps or tightens the setting.
  function automatic logic tighten_ok(input fcpi_pkg::fcpi_prot_t old_p, input fcpi_pkg::fcpi_prot_t new_p);
    tighten_ok = (new_p == old_p) ||
                 (old_p == `FCPI_PROT_RW && (new_p == `FCPI_PROT_RO || new_p == `FCPI_PROT_XO)) ||
                 (old_p == `FCPI_PROT_RO && new_p == `FCPI_PROT_XO);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] op_addr;
  logic [31:0] op_data;
  logic [15:0] usec;
  logic [1:0] raw;
  logic [1:0] int_en;
  fcpi_pkg::fcpi_prot_t prot [0:`FCPI_NUM_PB-1];
  fcpi_pkg::fcpi_prot_t saved [0:`FCPI_NUM_PB-1];
  logic saved_flag;
  fcpi_pkg::fcpi_state_t state;
  logic [15:0] cyc_cnt;
  logic [15:0] us_cnt;
  logic [`FCPI_EB_AW-1:0] word_idx;
  logic is_erase;
  logic [`FCPI_AW-1:0] cur_word;
  logic ap_take;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic wr_cmd;
  logic req_prog;
  logic req_erase;
  logic cmd_start;
  logic cmd_ok;
  logic cmd_bad;
  logic rd_bad;
  logic ev_done;
  logic [1:0] clr;
  logic [15:0] usec_eff;
  logic [7:0] prot_packed;
  logic [7:0] saved_packed;
  logic [31:0] reg_rd;
  logic arr_we;
  logic [`FCPI_AW-1:0] arr_waddr;
  logic [31:0] arr_rdata;
  logic [`FCPI_AW-1:0] rd_word;

  // ----------------------------------------------------------------
  // AHB-Lite handshake
  // ----------------------------------------------------------------
  // Zero wait states keep the slave simple; a write is applied in its data phase.
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign ap_take = i_hsel && i_htrans[1] && i_hready;

  // Capture the address phase of a write for use in the data phase.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_wr <= ap_take && i_hwrite && (i_haddr[31:8] == '0);
      dp_addr <= i_haddr[7:0];
    end
  end

  // Read data is sampled at the address phase and held until the next read.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_hrdata <= 32'h00000000;
    else if (ap_take && !i_hwrite)
      o_hrdata <= (i_haddr[31:8] == '0) ? reg_rd : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    prot_packed = {prot[3], prot[2], prot[1], prot[0]};
    saved_packed = {saved[3], saved[2], saved[1], saved[0]};
    unique case (i_haddr[7:0])
      `FCPI_OFF_ADDR: reg_rd = op_addr;
      `FCPI_OFF_DATA: reg_rd = op_data;
      `FCPI_OFF_USEC: reg_rd = {16'h0000, usec}; // RQ6
      `FCPI_OFF_RAW: reg_rd = {30'h00000000, raw}; // RQ11
      `FCPI_OFF_EN: reg_rd = {30'h00000000, int_en};
      `FCPI_OFF_MSK: reg_rd = {30'h00000000, raw & int_en}; // RQ11
      `FCPI_OFF_PROT: reg_rd = {24'h000000, prot_packed};
      `FCPI_OFF_STAT: reg_rd = {30'h00000000, saved_flag, o_busy};
      `FCPI_OFF_SAVED: reg_rd = {24'h000000, saved_packed};
      default: reg_rd = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Plain software registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      op_addr <= 32'h00000000;
      op_data <= 32'h00000000;
      usec <= `FCPI_CLK_MHZ;
      int_en <= 2'h0;
    end
    else if (dp_wr)
    begin
      if (dp_addr == `FCPI_OFF_ADDR)
        op_addr <= i_hwdata;
      if (dp_addr == `FCPI_OFF_DATA)
        op_data <= i_hwdata;
      if (dp_addr == `FCPI_OFF_USEC)
        usec <= i_hwdata[15:0]; // RQ6
      if (dp_addr == `FCPI_OFF_EN)
        int_en <= i_hwdata[1:0]; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // Protection settings
  // ----------------------------------------------------------------
  // Live settings act at once; loosening writes leave a block as it is.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < `FCPI_NUM_PB; i++)
        prot[i] <= `FCPI_PROT_RW;
    end
    else if (dp_wr && dp_addr == `FCPI_OFF_PROT)
    begin
      for (int i = 0; i < `FCPI_NUM_PB; i++)
        if (tighten_ok(prot[i], i_hwdata[2*i +: 2])) // RQ15
          prot[i] <= i_hwdata[2*i +: 2]; // RQ2 RQ9
    end
  end

  // The saved copy is written once; after that it can no longer change.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      saved_flag <= 1'b0;
      for (int i = 0; i < `FCPI_NUM_PB; i++)
        saved[i] <= `FCPI_PROT_RW;
    end
    else if (wr_cmd && i_hwdata[`FCPI_CMD_SAVE] && !saved_flag)
    begin
      saved_flag <= 1'b1; // RQ9
      for (int i = 0; i < `FCPI_NUM_PB; i++)
        saved[i] <= prot[i];
    end
  end

  // ----------------------------------------------------------------
  // Command decode and checks
  // ----------------------------------------------------------------
  // Program and erase commands during an operation are dropped, erase wins over program.
  assign wr_cmd = dp_wr && (dp_addr == `FCPI_OFF_CMD);
  assign req_erase = i_hwdata[`FCPI_CMD_ERASE];
  assign req_prog = i_hwdata[`FCPI_CMD_PROG];
  assign cmd_start = wr_cmd && (state == fcpi_pkg::ST_IDLE) && (req_erase || req_prog);
  assign cmd_ok = in_range(op_addr) && (prot[pb_of(op_addr)] == `FCPI_PROT_RW) && // RQ3 RQ4
                  (!req_erase || op_addr[`FCPI_EB_OFS_BITS-1:0] == '0);
  assign cmd_bad = cmd_start && !cmd_ok; // RQ17
  assign usec_eff = (usec == 16'h0000) ? 16'h0001 : usec;

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  // The pulse is a count of microseconds, each counted out in clock cycles.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= fcpi_pkg::ST_IDLE;
      cyc_cnt <= 16'h0000;
      us_cnt <= 16'h0000;
      word_idx <= '0;
      is_erase <= 1'b0;
      cur_word <= '0;
    end
    else
    begin
      unique case (state)
        fcpi_pkg::ST_IDLE:
        begin
          if (cmd_start && cmd_ok)
          begin
            state <= fcpi_pkg::ST_PULSE;
            is_erase <= req_erase;
            cur_word <= op_addr[`FCPI_BYTE_AW-1:2];
            us_cnt <= req_erase ? ERASE_US : PROG_US;
            cyc_cnt <= 16'h0000;
            word_idx <= '0;
          end
        end
        fcpi_pkg::ST_PULSE:
        begin
          if (cyc_cnt + 16'h0001 >= usec_eff) // RQ6
          begin
            cyc_cnt <= 16'h0000;
            if (us_cnt <= 16'h0001)
              state <= fcpi_pkg::ST_APPLY;
            else
              us_cnt <= us_cnt - 16'h0001;
          end
          else
            cyc_cnt <= cyc_cnt + 16'h0001;
        end
        fcpi_pkg::ST_APPLY:
        begin
          if (!is_erase || word_idx == `FCPI_EB_LAST)
            state <= fcpi_pkg::ST_IDLE;
          else
            word_idx <= word_idx + 8'h01; // RQ1
        end
      endcase
    end
  end

  assign o_busy = (state != fcpi_pkg::ST_IDLE);
  assign ev_done = (state == fcpi_pkg::ST_APPLY) && (!is_erase || word_idx == `FCPI_EB_LAST); // RQ8
  assign arr_we = (state == fcpi_pkg::ST_APPLY);
  assign arr_waddr = is_erase ? {cur_word[`FCPI_AW-1:`FCPI_EB_AW], word_idx} : cur_word; // RQ1 RQ5

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  assign rd_word = i_rd.addr[`FCPI_BYTE_AW-1:2];

  fcpi_array u_array (
    .i_clk(i_clk),
    .i_we(arr_we),
    .i_erase(is_erase),
    .i_waddr(arr_waddr),
    .i_wdata(op_data),
    .i_raddr(rd_word),
    .o_rdata(arr_rdata)
  );

  // ----------------------------------------------------------------
  // Read port with protection check
  // ----------------------------------------------------------------
  // Fetches pass any block; data and debug reads of fetch-only blocks are refused.
  assign rd_bad = i_rd.valid && (!in_range(i_rd.addr) ||
                  (i_rd.kind != `FCPI_RD_FETCH && prot[pb_of(i_rd.addr)] == `FCPI_PROT_XO)); // RQ3 RQ4

  // A refused read returns zero so protected contents never leak.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rd <= '0;
    else
    begin
      o_rd.valid <= i_rd.valid;
      o_rd.denied <= rd_bad;
      o_rd.data <= (i_rd.valid && !rd_bad) ? arr_rdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // A clear that meets a new event loses, so no event goes missing.
  assign clr = (dp_wr && dp_addr == `FCPI_OFF_CLR) ? i_hwdata[1:0] : 2'h0; // RQ16

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      raw <= 2'h0;
    else
    begin
      raw[`FCPI_INT_ACC] <= (cmd_bad || rd_bad) || (raw[`FCPI_INT_ACC] && !clr[`FCPI_INT_ACC]); // RQ7 RQ12
      raw[`FCPI_INT_DONE] <= ev_done || (raw[`FCPI_INT_DONE] && !clr[`FCPI_INT_DONE]); // RQ8 RQ12
    end
  end

  assign o_irq = |(raw & int_en); // RQ10

endmodule
`default_nettype wire

//--- dv/fcpi_top_monitor.sv
// Port checker for the flash controller top.
`timescale 1ns/1ps
`default_nettype none
module fcpi_top_monitor #(
  parameter logic [15:0] PROG_US = 16'h0014
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  // Read port.
  input wire fcpi_pkg::fcpi_rd_req_t i_rd,
  input wire fcpi_pkg::fcpi_rd_rsp_t o_rd,
  // Interrupt and status.
  input wire logic o_irq,
  input wire logic o_busy
);
  localparam int MAX_BUSY = 800;
  logic [15:0] busy_len;
  logic ap_cmd_wr;
  logic ap_rd;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Length of the running operation, so short pulses show up.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      busy_len <= 16'h0;
    else
      busy_len <= o_busy ? busy_len + 16'h1 : 16'h0;
  end
  // Address phases that later answers are traced back to.
  assign ap_cmd_wr = i_hsel && i_htrans[1] && i_hwrite && i_haddr == 32'h8;
  assign ap_rd = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  sequence s_clr_all;
    i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr == 32'h1c ##1 i_hwdata[1:0] == 2'h3;
  endsequence
  sequence s_oob_rd;
    i_rd.valid && i_rd.addr[31:13] != 19'h0;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oob_denied: assert property (s_oob_rd |=> o_rd.valid && o_rd.denied)
    else $error("out of range read not denied");
  a_fetch_allowed: assert property (i_rd.valid && i_rd.kind == 2'h0 && i_rd.addr[31:13] == 19'h0 |=> !o_rd.denied)
    else $error("fetch denied");
  a_denied_blank: assert property (o_rd.valid && o_rd.denied |-> o_rd.data == 32'h0)
    else $error("denied read leaks data");
  a_rsp_follows: assert property (o_rd.valid == $past(i_rd.valid))
    else $error("read answer not one cycle after request");
  a_busy_min: assert property ($fell(o_busy) |-> busy_len >= 16'(PROG_US + 16'h1))
    else $error("operation shorter than the program pulse");
  a_busy_max: assert property ($rose(o_busy) |-> ##[1:MAX_BUSY] !o_busy)
    else $error("operation does not end");
  a_busy_cause: assert property ($rose(o_busy) |-> $past(ap_cmd_wr, 2))
    else $error("operation started without a command");
  a_clr_drops_irq: assert property (s_clr_all |=> !o_irq)
    else $error("clear of all sources left the interrupt up");
  a_hrdata_hold: assert property ($changed(o_hrdata) |-> $past(ap_rd))
    else $error("read data changed without a read");
endmodule
bind fcpi_top fcpi_top_monitor #(.PROG_US(PROG_US)) u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_rd(i_rd),
  .o_rd(o_rd), .o_irq(o_irq), .o_busy(o_busy));
`default_nettype wire

//--- dv/fcpi_core_model.sv
// Model of the core and debugger reading the flash array.
`timescale 1ns/1ps
`default_nettype none
module fcpi_core_model (
  // Clock.
  input wire logic i_clk,
  // Read request and answer.
  output fcpi_pkg::fcpi_rd_req_t o_req,
  input wire fcpi_pkg::fcpi_rd_rsp_t i_rsp
);
  initial o_req = '0;
  // One word read after gap idle cycles; released lines show inverted values, never the old ones.
  task automatic rd(input logic [1:0] kind, input logic [31:0] addr, input int gap, output logic ok,
    output logic den, output logic [31:0] data);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_req <= {1'b1, kind, addr[31:2], 2'h0};
    @(posedge i_clk);
    o_req <= {1'b0, ~kind, ~addr};
    #1;
    ok = i_rsp.valid;
    den = i_rsp.denied;
    data = i_rsp.data;
  endtask
endmodule
`default_nettype wire

//--- dv/fcpi_top_tb.sv
// Self-checking bench for the flash controller top.
`timescale 1ns/1ps
`default_nettype none
module fcpi_top_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic o_hreadyout, o_hresp, o_irq, o_busy, ok, den;
  logic [31:0] o_hrdata, q;
  fcpi_pkg::fcpi_rd_req_t i_rd;
  fcpi_pkg::fcpi_rd_rsp_t o_rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  // The slave's own ready closes the loop, as with a single slave.
  always #5 i_clk = ~i_clk;
  fcpi_top #(.PROG_US(16'h2), .ERASE_US(16'h3)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .i_rd(i_rd), .o_rd(o_rd), .o_irq(o_irq), .o_busy(o_busy));
  fcpi_core_model u_core (.i_clk(i_clk), .o_req(i_rd), .i_rsp(o_rd));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bounded wait for ready; a hung slave ends the run.
  task automatic hwait;
    @(posedge i_clk);
    for (int k = 0; o_hreadyout !== 1'b1; k++)
    begin
      if (k > 50)
      begin
        n_mismatch++;
        summarize();
      end
      @(posedge i_clk);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_haddr <= a;
    hwait();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_haddr <= ~a;
    i_hwdata <= d;
    hwait();
    q = o_hrdata;
    chk("response", 32'h0, {31'h0, o_hresp});
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask
  task automatic rdw(input logic [1:0] kind, input logic [31:0] a, input logic d, input logic [31:0] e);
    u_core.rd(kind, a, 0, ok, den, q);
    chk("answer valid", 32'h1, {31'h0, ok});
    chk("denied", {31'h0, d}, {31'h0, den});
    chk("read data", e, q);
  endtask
  // Runs one command and counts the cycles that busy stands.
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] cmd);
    bus(1'b1, 32'h0, a);
    bus(1'b1, 32'h4, d);
    bus(1'b1, 32'h8, cmd);
    n = 0;
    #1;
    while (o_busy === 1'b1)
    begin
      n++;
      if (n > 1000)
      begin
        n_mismatch++;
        summarize();
      end
      @(posedge i_clk);
      #1;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk(32'hc, 32'h64);
    rdchk(32'h10, 32'h0);
    rdchk(32'h14, 32'h0);
    rdchk(32'h20, 32'h0);
    rdchk(32'h24, 32'h0);
    rdchk(32'h40, 32'h0);
  endtask
  task automatic t_ops;
    bus(1'b1, 32'hc, 32'h1);
    op(32'h400, 32'h0, 32'h2);
    chk("erase cycles", 32'd259, n);
    op(32'h400, 32'h0000ffff, 32'h1);
    chk("program cycles", 32'd3, n);
    op(32'h0, 32'h0, 32'h3);
    rdw(2'h1, 32'h400, 1'b0, 32'h0000ffff);
    rdw(2'h1, 32'h3fc, 1'b0, 32'hffffffff);
    bus(1'b1, 32'hc, 32'h3);
    op(32'h0, 32'hff00ff00, 32'h1);
    chk("slow program cycles", 32'd7, n);
    op(32'h0, 32'h0ff00ff0, 32'h1);
    rdw(2'h2, 32'h0, 1'b0, 32'h0f000f00);
    rdchk(32'h10, 32'h2);
    op(32'h404, 32'h0, 32'h2);
    chk("misaligned erase", 32'd0, n);
    rdchk(32'h10, 32'h3);
  endtask
  task automatic t_prot;
    bus(1'b1, 32'h1c, 32'h3);
    bus(1'b1, 32'h20, 32'h9);
    rdchk(32'h20, 32'h9);
    op(32'h0, 32'h0, 32'h2);
    chk("read-only erase", 32'd0, n);
    rdw(2'h1, 32'h0, 1'b0, 32'h0f000f00);
    rdw(2'h0, 32'h4, 1'b0, 32'hffffffff);
    rdchk(32'h10, 32'h1);
    u_core.rd(2'h0, 32'h800, 3, ok, den, q);
    chk("fetch-only fetch", 32'h0, {31'h0, den});
    rdw(2'h1, 32'h800, 1'b1, 32'h0);
    rdw(2'h2, 32'h804, 1'b1, 32'h0);
    op(32'h800, 32'h0, 32'h1);
    chk("fetch-only program", 32'd0, n);
    rdw(2'h1, 32'h2000, 1'b1, 32'h0);
    bus(1'b1, 32'h20, 32'h0);
    rdchk(32'h20, 32'h9);
    bus(1'b1, 32'h20, 32'h6);
    rdchk(32'h20, 32'ha);
    bus(1'b1, 32'h8, 32'h4);
    rdchk(32'h24, 32'h2);
    rdchk(32'h28, 32'ha);
  endtask
  task automatic t_irq;
    op(32'h1000, 32'hffffffff, 32'h1);
    chk("irq disabled", 32'h0, {31'h0, o_irq});
    bus(1'b1, 32'h14, 32'h2);
    #1;
    chk("irq done", 32'h1, {31'h0, o_irq});
    rdchk(32'h18, 32'h2);
    rdchk(32'h10, 32'h3);
    bus(1'b1, 32'h1c, 32'h2);
    #1;
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    rdchk(32'h10, 32'h1);
    bus(1'b1, 32'h14, 32'h3);
    bus(1'b1, 32'h1c, 32'h0);
    rdchk(32'h10, 32'h1);
    chk("irq violation", 32'h1, {31'h0, o_irq});
    bus(1'b1, 32'h1c, 32'h3);
    rdchk(32'h10, 32'h0);
  endtask
  // Main sequence: reset for twenty cycles, then each scenario in turn.
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_ops();
    t_prot();
    t_irq();
    summarize();
  end
endmodule
`default_nettype wire
